// *** hw/qpa_pkg.sv ***
/*
 * Package for the port access and multiplexer addressing block of the
 * queued converter module: register offsets, field positions, reset values
 * and the access-segment answers.
 * Assumes a 16-bit intermodule bus with word offsets inside the module.
 */
package qpa_pkg;

   // =====================================================================
   // Register offsets (word offsets inside the module).
   localparam logic [7:0] OFF_MODULE_CONFIG = 8'h00;
   localparam logic [7:0] OFF_FACTORY_TEST = 8'h02;
   localparam logic [7:0] OFF_INTERRUPT_SETUP = 8'h04;
   localparam logic [7:0] OFF_PORT_DATA = 8'h06;
   localparam logic [7:0] OFF_PORT_DIRECTION = 8'h08;
   localparam logic [7:0] OFF_CONTROL_0 = 8'h0a;
   // Offsets below this value form the supervisor-only segment.
   localparam logic [7:0] OFF_ASSIGNABLE_BASE = 8'h06;

   // =====================================================================
   // Field positions.
   localparam int MCR_SUPERVISOR_SPACE_SELECT_BIT = 7;
   localparam int MCR_ARB_LSB = 0;
   localparam int MCR_ARB_W = 4;
   localparam int CR0_MUX_BIT = 15;
   localparam int TRIG1_PIN = 3;
   localparam int TRIG2_PIN = 4;
   localparam int MUX_ADDR_W = 3;

   // =====================================================================
   // Reset values and fixed answers.
   localparam logic MCR_SUPERVISOR_SPACE_SELECT_RESET = 1'b1;
   localparam logic [3:0] MCR_ARB_RESET = 4'h0;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [15:0] TEST_RESET = 16'h0000;
   localparam logic [15:0] INTR_SETUP_RESET = 16'h0000;
   localparam logic [15:0] CR0_RESET = 16'h0000;
   localparam logic [15:0] SUPERVISOR_SPACE_SELECT_ONLY_USER_READ = 16'h0000;
   localparam logic [15:0] ASSIGNED_USER_READ = 16'hffff;
   localparam logic [7:0] DIRECTION_USED_MASK = 8'hff;

endpackage

// *** hw/qpa_chan_if.sv ***
/*
 * Interface carrying the channel-decode results from the decoder module
 * to the port block.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface qpa_chan_if;
   logic [2:0] mux_addr;
   logic [1:0] group_sel;
   logic [3:0] direct_chan;
   logic external;
   modport decoder (output mux_addr, output group_sel, output direct_chan,
      output external);
   modport user (input mux_addr, input group_sel, input direct_chan,
      input external);
endinterface

// *** hw/qpa_chan_decode.sv ***
/*
 * Splits a conversion command word channel number into the multiplexer
 * address and the grouped analog input selection.
 * Assumes the channel number is stable for the conversion it belongs to.
 */
`timescale 1ns/1ps
module qpa_chan_decode
   import qpa_pkg::*;
(
   input wire logic [5:0] chan_num, // Channel number from the command word.
   input wire logic mux_mode, // External-multiplex mode is on.
   qpa_chan_if.decoder dec // Decode results.
);
   // Bits 3..1 address the chips; bits 0 and 4 pick the grouped input.
   assign dec.mux_addr = chan_num[3:1];
   assign dec.group_sel = {chan_num[4], chan_num[0]};
   assign dec.direct_chan = chan_num[3:0];
   assign dec.external = mux_mode && (chan_num[5] == 1'b0);
endmodule

// *** hw/qpa_port_access.sv ***
/*
 * Bus access control, digital port logic and external multiplexer
 * addressing of the queued converter module.
 * Assumes a single-cycle synchronous 16-bit register port from the
 * intermodule bus, with supervisor state given by the bus master, and pins
 * that are asynchronous to core_clk.
 */
// Summary of operation
// - Supervisor-only segment is reachable only in supervisor mode.
// - User read of supervisor-only segment returns all zeros.
// - User read of supervisor-assigned segment returns all ones.
// - User writes to protected segments are dropped without effect.
// - Supervisor-select bit restricts or opens the assignable segment.
// - Config, test, interrupt registers supervisor-only; others assignable.
// - Arbitration number resets to zero; software loads a unique nonzero.
// - Arbitration number is driven out during interrupt acknowledge while a request is pending and the number is nonzero.
// - Pin synchroniser runs only after a port data access is decoded.
// - Port read gives pin level for inputs, latch for outputs.
// - Multiplex mode forces low three pins to drive the address.
// - Multiplex mode reads of address bits return address latches.
// - External trigger forces pin 3 or 4 to input, read live.
// - Two 8-bit ports: one bidirectional, one input only.
// - Port data registers are not reset.
// - Direction bit one makes an output, zero an input.
// - Reserved direction bits read zero and ignore writes.
// - Channel number yields address and grouped input; 32 external.
// - Multiplex bit in control register 0 selects external mode.
// - 16 internal channels; 20, 27, 34, 41 with one to four chips.
// - Grouped inputs carry even/odd low and even/odd high channels.
`timescale 1ns/1ps
module qpa_port_access
   import qpa_pkg::*;
(
   input wire logic core_clk, // System clock, 125 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic bus_sel, // Module selected this cycle.
   input wire logic bus_write, // One for write, zero for read.
   input wire logic bus_supervisor, // Bus master in supervisor mode.
   input wire logic [7:0] bus_addr, // Word offset inside the module.
   input wire logic [15:0] bus_wdata, // Write data.
   output logic [15:0] bus_rdata, // Read data, registered.
   output logic bus_ack, // Access done, one cycle later.
   input wire logic iack_cycle, // Interrupt acknowledge in progress.
   input wire logic irq_pending, // Module has a request at this level.
   output logic [3:0] arb_number_out, // Arbitration number driven out.
   output logic arb_drive, // Arbitration number is being driven.
   input wire logic [5:0] ccw_channel, // Channel of the current command.
   input wire logic trig1_mode, // Queue 1 in an external trigger mode.
   input wire logic trig2_mode, // Queue 2 in an external trigger mode.
   input wire logic [7:0] bidir_port_pins_in, // Bidirectional pin levels.
   output logic [7:0] bidir_port_pins_out, // Pin drive value.
   output logic [7:0] bidir_port_pins_oe, // Pin output enables.
   input wire logic [7:0] input_port_pins_in, // Input-only pin levels.
   output logic [1:0] group_select, // Grouped analog input selected.
   output logic [3:0] direct_channel, // Internal multiplexer channel.
   output logic external_select, // Conversion uses a grouped input.
   output logic [2:0] mux_address_outputs // Address to external chips.
);

   // =====================================================================
   // Registers.
   logic supervisor_space_select_reg;
   logic [3:0] arb_reg;
   logic [15:0] test_reg;
   logic [15:0] intr_reg;
   logic [15:0] cr0_reg;
   logic [7:0] dir_reg;
   logic [7:0] bidir_port_data_reg;
   logic [2:0] mux_addr_reg;
   logic sync_en_reg;
   logic [7:0] a_meta_reg;
   logic [7:0] a_sync_reg;
   logic [7:0] b_meta_reg;
   logic [7:0] b_sync_reg;
   logic [15:0] rdata_next;
   logic ack_reg;

   wire mux_mode = cr0_reg[CR0_MUX_BIT];

   qpa_chan_if chan ();

   qpa_chan_decode u_decode (
      .chan_num(ccw_channel),
      .mux_mode(mux_mode),
      .dec(chan.decoder)
   );

   // =====================================================================
   // Segment decode.
   wire in_supervisor_space_select_only = bus_addr < OFF_ASSIGNABLE_BASE;
   wire assign_restricted = supervisor_space_select_reg;
   wire user_mode = !bus_supervisor;
   wire blocked_supervisor_space_select = user_mode && in_supervisor_space_select_only;
   wire blocked_assign = user_mode && !in_supervisor_space_select_only && assign_restricted;
   wire allowed = bus_sel && !blocked_supervisor_space_select && !blocked_assign;
   wire wr_ok = allowed && bus_write;
   wire hit_mcr = bus_addr == OFF_MODULE_CONFIG;
   wire hit_test = bus_addr == OFF_FACTORY_TEST;
   wire hit_intr = bus_addr == OFF_INTERRUPT_SETUP;
   wire hit_data = bus_addr == OFF_PORT_DATA;
   wire hit_dir = bus_addr == OFF_PORT_DIRECTION;
   wire hit_cr0 = bus_addr == OFF_CONTROL_0;
   wire data_cycle = bus_sel && hit_data;

   // =====================================================================
   // Pin direction and port read.
   wire [7:0] trig_force;
   assign trig_force = {3'h0, trig2_mode, trig1_mode, 3'h0};
   wire [7:0] mux_force;
   assign mux_force = mux_mode ? 8'h07 : 8'h00;
   wire [7:0] dir_eff;
   assign dir_eff = (dir_reg | mux_force) & ~trig_force;
   wire [7:0] latch_value;
   assign latch_value = {bidir_port_data_reg[7:3],
      mux_mode ? mux_addr_reg : bidir_port_data_reg[2:0]};
   wire [7:0] bidir_port_data;
   assign bidir_port_data = (dir_eff & latch_value) |
      (~dir_eff & a_sync_reg);
   wire [7:0] input_port_data;
   assign input_port_data = b_sync_reg;

   // Open-drain drivers only pull low; a one lets the pin float high.
   assign bidir_port_pins_out = 8'h00;
   assign bidir_port_pins_oe = dir_eff & ~latch_value;
   assign mux_address_outputs = mux_addr_reg;
   assign group_select = chan.group_sel;
   assign direct_channel = chan.direct_chan;
   assign external_select = chan.external;

   // =====================================================================
   // Read data selection.
   wire [15:0] mcr_value;
   assign mcr_value = {8'h00, supervisor_space_select_reg, 3'h0, arb_reg};
   always_comb begin
      rdata_next = 16'h0000;
      if (bus_sel && !bus_write) begin
         if (blocked_supervisor_space_select) begin
            rdata_next = SUPERVISOR_SPACE_SELECT_ONLY_USER_READ;
         end else if (blocked_assign) begin
            rdata_next = ASSIGNED_USER_READ;
         end else if (hit_mcr) begin
            rdata_next = mcr_value;
         end else if (hit_test) begin
            rdata_next = test_reg;
         end else if (hit_intr) begin
            rdata_next = intr_reg;
         end else if (hit_data) begin
            rdata_next = {bidir_port_data, input_port_data};
         end else if (hit_dir) begin
            rdata_next = {dir_reg & DIRECTION_USED_MASK, 8'h00};
         end else if (hit_cr0) begin
            rdata_next = cr0_reg;
         end
      end
   end

   // =====================================================================
   // Control registers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         supervisor_space_select_reg <= MCR_SUPERVISOR_SPACE_SELECT_RESET;
         arb_reg <= MCR_ARB_RESET;
      end else if (wr_ok && hit_mcr) begin
         supervisor_space_select_reg <= bus_wdata[MCR_SUPERVISOR_SPACE_SELECT_BIT];
         arb_reg <= bus_wdata[MCR_ARB_LSB +: MCR_ARB_W];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         test_reg <= TEST_RESET;
         intr_reg <= INTR_SETUP_RESET;
         cr0_reg <= CR0_RESET;
      end else begin
         if (wr_ok && hit_test) test_reg <= bus_wdata;
         if (wr_ok && hit_intr) intr_reg <= bus_wdata;
         if (wr_ok && hit_cr0) cr0_reg <= bus_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dir_reg <= DIRECTION_RESET;
      end else if (wr_ok && hit_dir) begin
         dir_reg <= bus_wdata[15:8] & DIRECTION_USED_MASK;
      end
   end

   // Port data latch keeps its value through reset.
   always_ff @(posedge core_clk) begin
      if (wr_ok && hit_data) begin
         bidir_port_data_reg <= bus_wdata[15:8];
      end
   end

   // Multiplexer address latch follows the current command's channel in multiplex mode and holds otherwise.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mux_addr_reg <= 3'h0;
      end else if (mux_mode) begin
         mux_addr_reg <= chan.mux_addr;
      end
   end

   // =====================================================================
   // Gated pin synchronisers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_en_reg <= 1'b0;
      end else if (data_cycle) begin
         sync_en_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         a_meta_reg <= 8'h00;
         a_sync_reg <= 8'h00;
         b_meta_reg <= 8'h00;
         b_sync_reg <= 8'h00;
      end else if (sync_en_reg || data_cycle) begin
         a_meta_reg <= bidir_port_pins_in;
         a_sync_reg <= a_meta_reg;
         b_meta_reg <= input_port_pins_in;
         b_sync_reg <= b_meta_reg;
      end
   end

   // =====================================================================
   // Bus answer and arbitration.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= 16'h0000;
         ack_reg <= 1'b0;
      end else begin
         bus_rdata <= rdata_next;
         ack_reg <= bus_sel;
      end
   end
   assign bus_ack = ack_reg;

   // A zero number never takes part in arbitration.
   assign arb_drive = iack_cycle && irq_pending && (arb_reg != 4'h0);
   assign arb_number_out = arb_drive ? arb_reg : 4'h0;

endmodule

// *** verification/qpa_pin_model.sv ***
/* Far-side pin model: open-drain port pins with outside sources.
   Assumes the design drives low only through its output enables. */
`timescale 1ns/1ps
module qpa_pin_model (
   input wire logic [7:0] oe, // Design pulls the pin.
   input wire logic [7:0] drive, // Design drive level.
   input wire logic [7:0] ext, // Level of the outside source.
   output logic [7:0] pins // Resulting pin level.
);
   // A released pin shows the outside source, never the last drive.
   assign pins = (oe & drive) | (~oe & ext);
endmodule

// *** verification/qpa_port_access_chk.sv ***
/* Checker for qpa_port_access, bound to every instance.
   Assumes one clock domain and the registered bus answer. */
`timescale 1ns/1ps
module qpa_port_access_chk (
   input wire logic core_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic bus_sel, // Access.
   input wire logic bus_write, // Write.
   input wire logic bus_supervisor, // Supervisor.
   input wire logic [7:0] bus_addr, // Offset.
   input wire logic [15:0] bus_rdata, // Read data.
   input wire logic bus_ack, // Answer.
   input wire logic iack_cycle, // Acknowledge.
   input wire logic irq_pending, // Request.
   input wire logic [3:0] arb_number_out, // Number out.
   input wire logic arb_drive, // Number driven.
   input wire logic [5:0] ccw_channel, // Channel.
   input wire logic [7:0] bidir_port_pins_out, // Pin drive.
   input wire logic [7:0] bidir_port_pins_oe, // Pin enables.
   input wire logic [1:0] group_select, // Group.
   input wire logic [3:0] direct_channel, // Internal channel.
   input wire logic external_select, // Grouped input.
   input wire logic [2:0] mux_address_outputs // Address.
);
   // =====================================================================
   // Properties.
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_user_rd;
      bus_sel && !bus_write && !bus_supervisor;
   endsequence
   sequence s_answer;
      bus_ack ##0 bus_rdata == 16'h0000;
   endsequence
   property p_ack; bus_sel |=> bus_ack; endproperty
   property p_idle; !bus_sel |=> !bus_ack && bus_rdata == 16'h0000;
   endproperty
   property p_usr_supervisor_space_select; s_user_rd ##0 bus_addr < 8'h06 |=> s_answer;
   endproperty
   property p_arb;
      arb_drive |-> iack_cycle && irq_pending && arb_number_out != 4'h0;
   endproperty
   property p_arb_off;
      !(iack_cycle && irq_pending) |-> !arb_drive && arb_number_out == 4'h0;
   endproperty
   property p_grp;
      group_select == {ccw_channel[4], ccw_channel[0]} &&
         direct_channel == ccw_channel[3:0];
   endproperty
   property p_mux;
      external_select |=> mux_address_outputs == $past(ccw_channel[3:1]);
   endproperty
   property p_mux_oe;
      external_select |-> bidir_port_pins_oe[2:0] == ~mux_address_outputs;
   endproperty
   property p_od; bidir_port_pins_out == 8'h00; endproperty
   a_ack: assert property (p_ack) else $error("no answer"); // see CONTRACT
   a_idle: assert property (p_idle) else $error("idle answer"); // see CONTRACT
   a_usr_supervisor_space_select: assert property (p_usr_supervisor_space_select) else $error("user read");
   a_arb: assert property (p_arb) else $error("arb driven");
   a_arb_off: assert property (p_arb_off) else $error("arb idle");
   a_grp: assert property (p_grp) else $error("group");
   a_mux: assert property (p_mux) else $error("mux address");
   a_mux_oe: assert property (p_mux_oe) else $error("mux pins");
   a_od: assert property (p_od) else $error("pin drive");
endmodule
bind qpa_port_access qpa_port_access_chk u_chk (.*);

// *** verification/tb_top.sv ***
/* Self-checking testbench for qpa_port_access with a pin model.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module tb_top;
   import qpa_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, bus_sel = 1'b0, bus_write = 1'b0;
   logic bus_supervisor = 1'b1, iack_cycle = 1'b0, irq_pending = 1'b0;
   logic trig1_mode = 1'b0, trig2_mode = 1'b0;
   logic bus_ack, arb_drive, external_select;
   logic [7:0] bus_addr = 8'h00, input_port_pins_in = 8'h00, ext = 8'h00;
   logic [7:0] bidir_port_pins_in, bidir_port_pins_out, bidir_port_pins_oe;
   logic [15:0] bus_wdata = 16'h0000, bus_rdata;
   logic [5:0] ccw_channel = 6'h00;
   logic [3:0] arb_number_out, direct_channel;
   logic [1:0] group_select;
   logic [2:0] mux_address_outputs;
   logic [15:0] exp_q[$];
   int fail_count = 0;
   int checks = 0;
   qpa_port_access dut_u (.*);
   qpa_pin_model pin_u (.oe(bidir_port_pins_oe), .drive(bidir_port_pins_out),
      .ext(ext), .pins(bidir_port_pins_in));
   always #4 core_clk = ~core_clk;
   // =====================================================================
   // Tasks.
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task acc(input logic w, input logic s, input logic [7:0] a,
      input logic [15:0] d, input logic [15:0] e);
      @(posedge core_clk);
      bus_sel <= 1'b1;
      bus_write <= w;
      bus_supervisor <= s;
      bus_addr <= a;
      bus_wdata <= d;
      exp_q.push_back(e);
   endtask
   task idle(input int n);
      @(posedge core_clk);
      bus_sel <= 1'b0;
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task test_done;
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk)
      if (bus_ack === 1'b1)
         chk("bus_rdata", bus_rdata, exp_q.pop_front());
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      test_done();
   end
   // =====================================================================
   // Main sequence.
   initial begin
      void'($urandom(95990));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      ext <= $urandom();
      input_port_pins_in <= $urandom();
      for (int a = 0; a < 14; a += 2) begin
         if (a != 6)
            acc(0, 1, a[7:0], 0, a == 0 ? 16'h0080 : 16'h0000);
         if (a < 12)
            acc(0, 0, a[7:0], 0, a < 6 ? 16'h0000 : 16'hffff);
      end
      @(posedge core_clk);
      bus_sel <= 1'b0;
      iack_cycle <= 1'b1;
      irq_pending <= 1'b1;
      acc(1, 0, 8'h08, 16'hff00, 0);
      acc(1, 0, 8'h00, 16'h0005, 0);
      acc(0, 1, 8'h08, 0, 16'h0000);
      idle(2);
      chk("arb_drive", arb_drive, 0);
      acc(1, 1, 8'h00, 16'h0005, 0);
      acc(0, 0, 8'h08, 0, 16'h0000);
      acc(1, 0, 8'h08, 16'hf000, 0);
      acc(1, 0, 8'h06, 16'h5a00, 0);
      idle(4);
      chk("arb_number", arb_number_out, 4'h5);
      chk("arb_drive", arb_drive, 1);
      chk("pins_oe", bidir_port_pins_oe, 8'ha0);
      acc(0, 0, 8'h06, 0, {4'h5, ext[3:0], input_port_pins_in});
      acc(1, 1, 8'h0a, 16'h8000, 0);
      acc(1, 1, 8'h08, 16'hff00, 0);
      acc(1, 1, 8'h06, 16'ha000, 0);
      idle(1);
      for (int c = 0; c < 33; c++) begin
         @(posedge core_clk);
         ccw_channel <= c[5:0];
         @(posedge core_clk);
         #1;
         chk("group", group_select, {c[4], c[0]});
         chk("external", external_select, c < 32);
         chk("mux", mux_address_outputs, c[3:1]);
      end
      @(posedge core_clk);
      ccw_channel <= 6'h0d;
      trig1_mode <= 1'b1;
      trig2_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      acc(0, 1, 8'h06, 0, {3'h5, ext[4:3], 3'h6, input_port_pins_in});
      idle(2);
      chk("pins_oe", bidir_port_pins_oe, 8'h41);
      @(posedge core_clk);
      trig1_mode <= 1'b0;
      trig2_mode <= 1'b0;
      input_port_pins_in <= 8'h00;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      acc(0, 1, 8'h00, 0, 16'h0080);
      acc(1, 1, 8'h08, 16'hff00, 0);
      acc(0, 1, 8'h06, 0, 16'ha000);
      idle(2);
      test_done();
   end
endmodule
